// file: design/smc_pkg.sv
// Purpose: shared constants and types for the mode controller
// Assumes: 20 MHz system clock, oscillator ticks derived by division
// Notes: times are kept in their printed unit, counts derived from them
package smc_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned TICK_HZ = 1000;
  localparam int unsigned FAST_DIV = CLK_HZ / TICK_HZ;
  localparam int unsigned SLOW_DIV = FAST_DIV * 2;
  localparam int unsigned RESET_DURATION_MS = 15;
  localparam int unsigned CONFIG_TIMEOUT_MS = 350;
  localparam int unsigned RESET_DURATION_TICKS = RESET_DURATION_MS * TICK_HZ / 1000;
  localparam int unsigned CONFIG_TIMEOUT_TICKS = CONFIG_TIMEOUT_MS * TICK_HZ / 1000;
  localparam int unsigned CYCLIC_PERIOD_TICKS = 32;
  localparam int unsigned CYCLIC_ON_TICKS = 1;
  localparam int unsigned CNT_W = 24;
  localparam logic [1:0] REQ_STANDBY = 2'h0;
  localparam logic [1:0] REQ_NORMAL = 2'h1;
  localparam logic [1:0] REQ_STOP = 2'h2;
  localparam logic [1:0] REQ_SLEEP = 2'h3;
  typedef enum logic [2:0] {
    SMC_RESET, SMC_NORMAL_REQ, SMC_NORMAL, SMC_STANDBY, SMC_STOP, SMC_SLEEP
  } smc_mode_t;
endpackage

// file: design/smc_tick_if.sv
// Purpose: carries the oscillator tick and its selection between modules
// Assumes: one clock domain
// Notes: slow_sel picks the low-accuracy oscillator
`timescale 1ns/1ps
interface smc_tick_if;
  logic slow_sel;
  logic tick;
  modport ctrl (output slow_sel, input tick);
  modport gen (input slow_sel, output tick);
endinterface

// file: design/smc_tick_gen.sv
// Purpose: models the two internal oscillators as tick enables
// Assumes: divider counts from the package
// Notes: a switch of oscillator restarts the divider
`timescale 1ns/1ps
module smc_tick_gen
  import smc_pkg::*;
#(
  parameter int unsigned FAST = FAST_DIV,
  parameter int unsigned SLOW = SLOW_DIV
)
(
  input wire logic clk,
  input wire logic rst,
  smc_tick_if.gen tif
);
  logic [CNT_W-1:0] div;
  logic last_sel;
  wire [CNT_W-1:0] limit = tif.slow_sel ? CNT_W'(SLOW - 1) : CNT_W'(FAST - 1);
  wire wrap = (div >= limit) || (last_sel != tif.slow_sel);
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      div <= '0;
      tif.tick <= 1'b0;
      last_sel <= 1'b0;
    end
    else
    begin
      last_sel <= tif.slow_sel;
      div <= wrap ? '0 : div + 1'b1;
      tif.tick <= (div >= limit);
    end
  end
endmodule // smc_tick_gen

// file: design/smc_sync.sv
// Purpose: two-flop synchroniser for a bus of pin levels
// Assumes: levels change slowly relative to the clock
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module smc_sync #(parameter int unsigned W = 1)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta <= '0;
      q <= '0;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // smc_sync

// file: design/smc_mode_ctrl.sv
// Purpose: operating-mode sequencer and supply flag logic of a system basis chip
// Assumes: comparator, watchdog and CAN results arrive as pin levels
// Notes: flags are cleared by a clear strobe from the host command logic
// What this block does
// - latch battery below 3.0 V always
// - 6.0 V warning only Normal/Standby, maskable
// - regulator hot sets two warn flags, shutdown
// - second regulator below 4.0 V flags low
// - switch overtemp sets two status bits
// - switch follows on bit in Normal/Standby
// - cyclic switch pulses in Sleep and Stop
// - fast oscillator awake, slow in Sleep/Stop
// - host selects modes; Normal Request automatic
// - Standby keeps main regulator only
// - Standby blocks CAN send, flags wake
// - Normal enables all; host services watchdog
// - Stop: second off, main low current
// - Stop only by command; watchdog per bit
// - Sleep: regulators off, wake sources listed
// - Sleep wake and power-up pass Reset
// - Reset holds output low for duration
// - undervoltage or watchdog faults enter Reset
// - Stop wake goes straight to Normal Request
// - Normal Request: main on, timeout starts
// - configuration ends timeout, enters requested mode
// - unconfigured timeout loops through Reset
// - unconfigured after Sleep wake returns Sleep
`timescale 1ns/1ps
module smc_mode_ctrl
  import smc_pkg::*;
#(
  parameter int unsigned RST_TICKS = RESET_DURATION_TICKS,
  parameter int unsigned NR_TICKS = CONFIG_TIMEOUT_TICKS
)
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic BATT_BELOW_3V,
  input wire logic BATT_BELOW_6V,
  input wire logic REG_TEMP_WARN,
  input wire logic REG_TEMP_SHUTDOWN,
  input wire logic MAIN_REG_UNDERVOLT,
  input wire logic MAIN_REG_OVERCURRENT,
  input wire logic SECOND_REG_BELOW_4V,
  input wire logic SWITCH_OVERTEMP_IN,
  input wire logic WATCHDOG_FAULT,
  input wire logic [3:0] WAKE_INPUTS,
  input wire logic [3:0] WAKE_ENABLE,
  input wire logic CYCLIC_SENSE_EN,
  input wire logic FORCED_WAKE,
  input wire logic CAN_RX_ACTIVE,
  input wire logic CHIP_SELECT_N,
  input wire logic MODE_REQ_VALID,
  input wire logic [1:0] MODE_REQ,
  input wire logic WATCHDOG_PERIOD_WRITE,
  input wire logic STOP_WATCHDOG_ENABLE,
  input wire logic SWITCH_ON_BIT,
  input wire logic BATT_WARN_MASK,
  input wire logic FLAG_CLEAR,
  output logic [2:0] MODE,
  output logic RESET_N,
  output logic MAIN_REG_ON,
  output logic MAIN_REG_LOW_CURRENT,
  output logic SECOND_REG_DRIVE,
  output logic HIGH_SIDE_SWITCH,
  output logic CAN_TX_ENABLE,
  output logic WATCHDOG_RUN,
  output logic WATCHDOG_CONFIG_LOAD,
  output logic SLOW_OSC_SEL,
  output logic BATTERY_FAIL_FLAG,
  output logic BATT_WARN_FLAG,
  output logic BATT_WARN_IRQ,
  output logic REGULATOR_TEMP_WARN_MCR,
  output logic REGULATOR_TEMP_WARN_INT,
  output logic SECOND_REG_LOW,
  output logic SWITCH_OVERTEMP,
  output logic SWITCH_OR_SECOND_LOW,
  output logic CAN_WAKE_FLAG
);
  smc_tick_if tif();
  smc_mode_t mode;
  smc_mode_t next_mode;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] cyc;
  logic from_sleep;
  logic [1:0] target;
  logic [3:0] wake_prev;

  // status, wake, CAN, chip select, cyclic enable and MODE_REQ_VALID pins pass two flops; MODE_REQ and the other host control bits are used directly
  localparam int unsigned NS = 18;
  logic [NS-1:0] s;
  smc_sync #(.W(NS)) u_sync (
    .clk(CLK),
    .rst(RST),
    .d({BATT_BELOW_3V, BATT_BELOW_6V, REG_TEMP_WARN, REG_TEMP_SHUTDOWN, MAIN_REG_UNDERVOLT,
        MAIN_REG_OVERCURRENT, SECOND_REG_BELOW_4V, SWITCH_OVERTEMP_IN, WATCHDOG_FAULT,
        WAKE_INPUTS, FORCED_WAKE, CAN_RX_ACTIVE, CHIP_SELECT_N, CYCLIC_SENSE_EN, MODE_REQ_VALID}),
    .q(s)
  );
  wire b3 = s[17];
  wire b6 = s[16];
  wire tw = s[15];
  wire tsd = s[14];
  wire uv = s[13];
  wire oc = s[12];
  wire v4 = s[11];
  wire hot = s[10];
  wire wdf = s[9];
  wire [3:0] wk = s[8:5];
  wire fw = s[4];
  wire canrx = s[3];
  wire csn = s[2];
  wire cyc_en = s[1];
  wire req_v = s[0];

  smc_tick_gen u_tick (
    .clk(CLK),
    .rst(RST),
    .tif(tif)
  );
  assign tif.slow_sel = (mode == SMC_SLEEP) || (mode == SMC_STOP);
  wire tick = tif.tick;

  wire asleep = (mode == SMC_SLEEP) || (mode == SMC_STOP);
  wire awake_run = (mode == SMC_NORMAL) || (mode == SMC_STANDBY);
  wire level_wake = |((wk ^ wake_prev) & WAKE_ENABLE);
  wire cyc_sample = cyc_en && tick && (cyc == '0);
  wire cyc_wake = cyc_sample && |((wk ^ wake_prev) & WAKE_ENABLE);
  wire sleep_wake = level_wake || cyc_wake || fw || canrx;
  wire stop_wake = sleep_wake || !csn || oc;
  wire wd_active = (mode == SMC_STOP) ? STOP_WATCHDOG_ENABLE : awake_run;
  wire reset_cause = uv || (wd_active && wdf);
  wire cnt_done = tick && (cnt == '0);
  wire cmd = req_v && awake_run;

  function automatic smc_mode_t req_mode(input logic [1:0] r);
    unique case (r)
      REQ_STANDBY: req_mode = SMC_STANDBY;
      REQ_NORMAL: req_mode = SMC_NORMAL;
      REQ_STOP: req_mode = SMC_STOP;
      REQ_SLEEP: req_mode = SMC_SLEEP;
    endcase
  endfunction

  always_comb
  begin
    next_mode = mode;
    unique case (mode)
      SMC_RESET:
        if (cnt_done && !uv)
          next_mode = SMC_NORMAL_REQ;
      SMC_NORMAL_REQ:
        if (uv)
          next_mode = SMC_RESET;
        else if (WATCHDOG_PERIOD_WRITE)
          next_mode = (target == REQ_NORMAL) ? SMC_NORMAL : SMC_STANDBY;
        else if (cnt_done)
          next_mode = from_sleep ? SMC_SLEEP : SMC_RESET;
      SMC_NORMAL, SMC_STANDBY:
        if (reset_cause)
          next_mode = SMC_RESET;
        else if (cmd)
          next_mode = req_mode(MODE_REQ);
      SMC_STOP:
        if (reset_cause)
          next_mode = SMC_RESET;
        else if (stop_wake)
          next_mode = SMC_NORMAL_REQ;
      SMC_SLEEP:
        if (sleep_wake)
          next_mode = SMC_RESET;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      mode <= SMC_RESET;
      cnt <= CNT_W'(RST_TICKS - 1);
      from_sleep <= 1'b0;
      target <= REQ_NORMAL;
    end
    else
    begin
      mode <= next_mode;
      if (next_mode != mode)
        cnt <= (next_mode == SMC_RESET) ? CNT_W'(RST_TICKS - 1) : CNT_W'(NR_TICKS - 1);
      else if (tick && cnt != '0)
        cnt <= cnt - 1'b1;
      if (mode == SMC_SLEEP && next_mode == SMC_RESET)
        from_sleep <= 1'b1;
      else if (mode == SMC_NORMAL_REQ && next_mode != SMC_NORMAL_REQ)
        from_sleep <= 1'b0;
      if (cmd && (MODE_REQ == REQ_NORMAL || MODE_REQ == REQ_STANDBY))
        target <= MODE_REQ;
    end
  end

  // wake baseline captured each awake cycle, and when asleep only on a level wake or cyclic sample, so level changes count once
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      wake_prev <= '0;
      cyc <= '0;
    end
    else
    begin
      if (!asleep || level_wake || cyc_sample)
        wake_prev <= wk;
      if (tick)
        cyc <= (cyc >= CNT_W'(CYCLIC_PERIOD_TICKS - 1)) ? '0 : cyc + 1'b1;
    end
  end
  wire cyc_on = asleep && cyc_en && (cyc < CNT_W'(CYCLIC_ON_TICKS));

  // outputs registered; set wins over clear for every flag
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      MODE <= 3'h0;
      RESET_N <= 1'b0;
      MAIN_REG_ON <= 1'b1;
      MAIN_REG_LOW_CURRENT <= 1'b0;
      SECOND_REG_DRIVE <= 1'b0;
      HIGH_SIDE_SWITCH <= 1'b0;
      CAN_TX_ENABLE <= 1'b0;
      WATCHDOG_RUN <= 1'b0;
      WATCHDOG_CONFIG_LOAD <= 1'b0;
      SLOW_OSC_SEL <= 1'b0;
      BATTERY_FAIL_FLAG <= 1'b0;
      BATT_WARN_FLAG <= 1'b0;
      BATT_WARN_IRQ <= 1'b0;
      REGULATOR_TEMP_WARN_MCR <= 1'b0;
      REGULATOR_TEMP_WARN_INT <= 1'b0;
      SECOND_REG_LOW <= 1'b0;
      SWITCH_OVERTEMP <= 1'b0;
      SWITCH_OR_SECOND_LOW <= 1'b0;
      CAN_WAKE_FLAG <= 1'b0;
    end
    else
    begin
      MODE <= 3'(next_mode);
      RESET_N <= (next_mode != SMC_RESET) && (next_mode != SMC_SLEEP);
      MAIN_REG_ON <= (next_mode != SMC_SLEEP) && !tsd;
      MAIN_REG_LOW_CURRENT <= (next_mode == SMC_STOP);
      SECOND_REG_DRIVE <= (next_mode == SMC_NORMAL);
      HIGH_SIDE_SWITCH <= !hot && ((awake_run && SWITCH_ON_BIT) || cyc_on);
      CAN_TX_ENABLE <= (next_mode == SMC_NORMAL);
      WATCHDOG_RUN <= (next_mode == SMC_NORMAL) || (next_mode == SMC_STANDBY)
                      || (next_mode == SMC_STOP && STOP_WATCHDOG_ENABLE);
      WATCHDOG_CONFIG_LOAD <= (mode == SMC_NORMAL_REQ) && WATCHDOG_PERIOD_WRITE;
      SLOW_OSC_SEL <= tif.slow_sel;
      BATTERY_FAIL_FLAG <= b3 || (BATTERY_FAIL_FLAG && !FLAG_CLEAR);
      BATT_WARN_FLAG <= (awake_run && b6) || (BATT_WARN_FLAG && !FLAG_CLEAR);
      BATT_WARN_IRQ <= ((awake_run && b6) || (BATT_WARN_FLAG && !FLAG_CLEAR)) && !BATT_WARN_MASK;
      REGULATOR_TEMP_WARN_MCR <= tw || (REGULATOR_TEMP_WARN_MCR && !FLAG_CLEAR);
      REGULATOR_TEMP_WARN_INT <= tw || (REGULATOR_TEMP_WARN_INT && !FLAG_CLEAR);
      SECOND_REG_LOW <= v4 || (SECOND_REG_LOW && !FLAG_CLEAR);
      SWITCH_OVERTEMP <= hot || (SWITCH_OVERTEMP && !FLAG_CLEAR);
      SWITCH_OR_SECOND_LOW <= hot || v4 || (SWITCH_OR_SECOND_LOW && !FLAG_CLEAR);
      CAN_WAKE_FLAG <= ((mode == SMC_STANDBY) && canrx) || (CAN_WAKE_FLAG && !FLAG_CLEAR);
    end
  end

  a_stop_by_cmd: assert property (@(posedge CLK) disable iff (RST)
    (next_mode == SMC_STOP && mode != SMC_STOP) |-> (cmd && MODE_REQ == REQ_STOP))
    else $error("stop entered without command");
  a_sleep_wake_reset: assert property (@(posedge CLK) disable iff (RST)
    (mode == SMC_SLEEP && next_mode != SMC_SLEEP) |-> next_mode == SMC_RESET)
    else $error("sleep wake skipped reset");
  a_stop_wake_direct: assert property (@(posedge CLK) disable iff (RST)
    (mode == SMC_STOP && !reset_cause && stop_wake) |=> mode == SMC_NORMAL_REQ)
    else $error("stop wake not direct");
  a_reset_low: assert property (@(posedge CLK) disable iff (RST)
    (mode == SMC_RESET) |=> !RESET_N || $past(next_mode) != SMC_RESET)
    else $error("reset output high in reset");
  a_batt_latch: assert property (@(posedge CLK) disable iff (RST)
    b3 |=> BATTERY_FAIL_FLAG)
    else $error("battery fail not latched");
  a_v2_off_standby: assert property (@(posedge CLK) disable iff (RST)
    (next_mode == SMC_STANDBY) |=> !SECOND_REG_DRIVE && MAIN_REG_ON || $past(tsd))
    else $error("standby regulator state wrong");
  a_osc_select: assert property (@(posedge CLK) disable iff (RST)
    asleep |=> SLOW_OSC_SEL)
    else $error("slow oscillator not selected");
  a_nr_timeout: assert property (@(posedge CLK) disable iff (RST)
    (mode == SMC_NORMAL_REQ && cnt_done && !uv && !WATCHDOG_PERIOD_WRITE && !from_sleep)
    |=> mode == SMC_RESET)
    else $error("timeout did not reset");
  a_sleep_return: assert property (@(posedge CLK) disable iff (RST)
    (mode == SMC_NORMAL_REQ && cnt_done && !uv && !WATCHDOG_PERIOD_WRITE && from_sleep)
    |=> mode == SMC_SLEEP)
    else $error("no return to sleep");

  // outputs held against the mode actually entered, so a slip in the output decode shows here
  a_warn_run_only: assert property (@(posedge CLK) disable iff (RST)
    (!awake_run && !BATT_WARN_FLAG) |=> !BATT_WARN_FLAG)
    else $error("battery warning set outside normal or standby");
  a_irq_mask: assert property (@(posedge CLK) disable iff (RST)
    BATT_WARN_IRQ |-> (BATT_WARN_FLAG && !$past(BATT_WARN_MASK)))
    else $error("masked battery warning reached interrupt");
  a_temp_both: assert property (@(posedge CLK) disable iff (RST)
    REGULATOR_TEMP_WARN_MCR == REGULATOR_TEMP_WARN_INT)
    else $error("temperature warn flags differ");
  a_temp_shutdown: assert property (@(posedge CLK) disable iff (RST)
    tsd |=> !MAIN_REG_ON)
    else $error("regulator stays on when too hot");
  a_second_low: assert property (@(posedge CLK) disable iff (RST)
    v4 |=> (SECOND_REG_LOW && SWITCH_OR_SECOND_LOW))
    else $error("second regulator low not flagged");
  a_switch_hot: assert property (@(posedge CLK) disable iff (RST)
    hot |=> (SWITCH_OVERTEMP && SWITCH_OR_SECOND_LOW && !HIGH_SIDE_SWITCH))
    else $error("switch overtemp not flagged");
  a_switch_follow: assert property (@(posedge CLK) disable iff (RST)
    (awake_run && SWITCH_ON_BIT && !hot) |=> HIGH_SIDE_SWITCH)
    else $error("switch ignores on bit");
  a_switch_idle: assert property (@(posedge CLK) disable iff (RST)
    (!awake_run && !cyc_on) |=> !HIGH_SIDE_SWITCH)
    else $error("switch on outside run or cyclic slot");
  a_mode_cmd: assert property (@(posedge CLK) disable iff (RST)
    (cmd && !reset_cause) |-> next_mode == req_mode(MODE_REQ))
    else $error("mode command not followed");
  a_standby_out: assert property (@(posedge CLK) disable iff (RST)
    (mode == SMC_STANDBY) |-> (!CAN_TX_ENABLE && !SECOND_REG_DRIVE && WATCHDOG_RUN))
    else $error("standby outputs wrong");
  a_normal_out: assert property (@(posedge CLK) disable iff (RST)
    (mode == SMC_NORMAL) |-> (SECOND_REG_DRIVE && CAN_TX_ENABLE && WATCHDOG_RUN))
    else $error("normal outputs wrong");
  a_stop_out: assert property (@(posedge CLK) disable iff (RST)
    (mode == SMC_STOP)
    |-> (MAIN_REG_LOW_CURRENT && !SECOND_REG_DRIVE && WATCHDOG_RUN == $past(STOP_WATCHDOG_ENABLE)))
    else $error("stop outputs wrong");
  a_sleep_out: assert property (@(posedge CLK) disable iff (RST)
    (mode == SMC_SLEEP) |-> (!MAIN_REG_ON && !SECOND_REG_DRIVE && !RESET_N && !WATCHDOG_RUN))
    else $error("sleep outputs wrong");
  a_fault_reset: assert property (@(posedge CLK) disable iff (RST)
    (awake_run && (uv || wdf)) |=> mode == SMC_RESET)
    else $error("fault did not enter reset");
  a_reset_holds: assert property (@(posedge CLK) disable iff (RST)
    (mode == SMC_RESET && !cnt_done) |=> (mode == SMC_RESET && !RESET_N))
    else $error("reset left before duration");
  a_nr_out: assert property (@(posedge CLK) disable iff (RST)
    (mode == SMC_NORMAL_REQ) |-> (RESET_N && !SECOND_REG_DRIVE && (MAIN_REG_ON || $past(tsd))))
    else $error("normal request outputs wrong");
  a_config_load: assert property (@(posedge CLK) disable iff (RST)
    (mode == SMC_NORMAL_REQ && WATCHDOG_PERIOD_WRITE && !uv)
    |=> (WATCHDOG_CONFIG_LOAD && (mode == SMC_NORMAL || mode == SMC_STANDBY)))
    else $error("configuration not applied");
endmodule // smc_mode_ctrl

// file: testbench/smc_host_model.sv
// Purpose: host microcontroller that commands the mode controller
// Assumes: every command changes just after a rising clock edge
// Notes: chip select rests high, the level of its pull-up
`timescale 1ns/1ps
module smc_host_model
(
  input wire logic clk,
  output logic req_valid,
  output logic [1:0] req,
  output logic period_write,
  output logic cs_n
);
  initial
  begin
    req_valid = 1'b0;
    req = 2'h1;
    period_write = 1'b0;
    cs_n = 1'b1;
  end
  // req stays put after valid drops: the controller reads it only once valid has crossed its synchroniser
  task automatic send_mode(input logic [1:0] m);
    @(posedge clk);
    req_valid <= 1'b1;
    req <= m;
    @(posedge clk);
    req_valid <= 1'b0;
  endtask
  task automatic configure();
    @(posedge clk);
    period_write <= 1'b1;
    @(posedge clk);
    period_write <= 1'b0;
  endtask
  task automatic cs_wake();
    @(posedge clk);
    cs_n <= 1'b0;
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
  endtask
endmodule // smc_host_model

// file: testbench/test_sbc_mode_controller.sv
// Purpose: self-checking bench for the mode controller
// Assumes: reset and timeout counts cut to one tick each
// Notes: a tick is still 20000 clocks awake and 40000 in Sleep/Stop, so the mode timeouts dominate the run
`timescale 1ns/1ps
module test_sbc_mode_controller;
  import smc_pkg::*;
  logic CLK;
  logic RST = 1'b1;
  logic BATT_BELOW_3V = 1'b0, BATT_BELOW_6V = 1'b0, REG_TEMP_WARN = 1'b0, REG_TEMP_SHUTDOWN = 1'b0;
  logic MAIN_REG_UNDERVOLT = 1'b0, MAIN_REG_OVERCURRENT = 1'b0, SECOND_REG_BELOW_4V = 1'b0;
  logic SWITCH_OVERTEMP_IN = 1'b0, WATCHDOG_FAULT = 1'b0, CYCLIC_SENSE_EN = 1'b0, FORCED_WAKE = 1'b0;
  logic CAN_RX_ACTIVE = 1'b0, STOP_WATCHDOG_ENABLE = 1'b0, SWITCH_ON_BIT = 1'b0;
  logic BATT_WARN_MASK = 1'b0, FLAG_CLEAR = 1'b0;
  logic [3:0] WAKE_INPUTS = 4'h0, WAKE_ENABLE = 4'h0;
  wire logic CHIP_SELECT_N, MODE_REQ_VALID, WATCHDOG_PERIOD_WRITE;
  wire logic [1:0] MODE_REQ;
  logic [2:0] MODE;
  logic RESET_N, MAIN_REG_ON, MAIN_REG_LOW_CURRENT, SECOND_REG_DRIVE, HIGH_SIDE_SWITCH, CAN_TX_ENABLE;
  logic WATCHDOG_RUN, WATCHDOG_CONFIG_LOAD, SLOW_OSC_SEL, BATTERY_FAIL_FLAG, BATT_WARN_FLAG, BATT_WARN_IRQ;
  logic REGULATOR_TEMP_WARN_MCR, REGULATOR_TEMP_WARN_INT, SECOND_REG_LOW, SWITCH_OVERTEMP;
  logic SWITCH_OR_SECOND_LOW, CAN_WAKE_FLAG;
  logic saw_reset = 1'b0;
  int fails = 0;
  int check_count = 0;

  smc_mode_ctrl #(.RST_TICKS(1), .NR_TICKS(1)) uut (
    .CLK, .RST, .BATT_BELOW_3V, .BATT_BELOW_6V, .REG_TEMP_WARN, .REG_TEMP_SHUTDOWN, .MAIN_REG_UNDERVOLT,
    .MAIN_REG_OVERCURRENT, .SECOND_REG_BELOW_4V, .SWITCH_OVERTEMP_IN, .WATCHDOG_FAULT, .WAKE_INPUTS,
    .WAKE_ENABLE, .CYCLIC_SENSE_EN, .FORCED_WAKE, .CAN_RX_ACTIVE, .CHIP_SELECT_N, .MODE_REQ_VALID, .MODE_REQ,
    .WATCHDOG_PERIOD_WRITE, .STOP_WATCHDOG_ENABLE, .SWITCH_ON_BIT, .BATT_WARN_MASK, .FLAG_CLEAR, .MODE,
    .RESET_N, .MAIN_REG_ON, .MAIN_REG_LOW_CURRENT, .SECOND_REG_DRIVE, .HIGH_SIDE_SWITCH, .CAN_TX_ENABLE,
    .WATCHDOG_RUN, .WATCHDOG_CONFIG_LOAD, .SLOW_OSC_SEL, .BATTERY_FAIL_FLAG, .BATT_WARN_FLAG, .BATT_WARN_IRQ,
    .REGULATOR_TEMP_WARN_MCR, .REGULATOR_TEMP_WARN_INT, .SECOND_REG_LOW, .SWITCH_OVERTEMP,
    .SWITCH_OR_SECOND_LOW, .CAN_WAKE_FLAG
  );
  smc_host_model host (.clk(CLK), .req_valid(MODE_REQ_VALID), .req(MODE_REQ),
    .period_write(WATCHDOG_PERIOD_WRITE), .cs_n(CHIP_SELECT_N));

  initial
  begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  always @(negedge CLK)
    if (MODE === SMC_RESET)
      saw_reset = 1'b1;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH at %0t: %s", $time, what);
    end
  endtask
  // outputs are read on the falling edge, clear of the rising edge that updates them
  task automatic step(input int n);
    repeat (n) @(negedge CLK);
  endtask
  task automatic wait_mode(input logic [2:0] m, input int limit, input string what);
    for (int i = 0; i < limit && MODE !== m; i++)
      @(negedge CLK);
    chk(MODE, m, what);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    #4500000;
    fails++;
    $display("MISMATCH at %0t: run timed out", $time);
    conclude();
  end

  initial
  begin
    repeat (3) @(posedge CLK);
    step(1);
    chk({MODE, RESET_N}, 4'h0, "reset mode, output low");
    repeat (3) @(posedge CLK);
    RST <= 1'b0;
    step(50);
    chk({MODE, RESET_N}, 4'h0, "reset output held");
    wait_mode(SMC_NORMAL_REQ, 25000, "reset to normal request");
    chk({RESET_N, MAIN_REG_ON, SECOND_REG_DRIVE}, 3'h6, "normal request supplies");
    chk(SLOW_OSC_SEL, 1'b0, "fast oscillator awake");
    host.configure();
    step(1);
    chk(MODE, SMC_NORMAL, "configured to normal");
    chk({WATCHDOG_CONFIG_LOAD, SECOND_REG_DRIVE, CAN_TX_ENABLE}, 3'h7, "normal outputs");
    chk(WATCHDOG_RUN, 1'b1, "watchdog runs in normal");
    step(1);
    chk(WATCHDOG_CONFIG_LOAD, 1'b0, "config load one cycle");
    $display("test power up done");
    @(posedge CLK);
    {BATT_BELOW_3V, BATT_BELOW_6V, REG_TEMP_WARN, SECOND_REG_BELOW_4V, SWITCH_OVERTEMP_IN} <= 5'h1f;
    SWITCH_ON_BIT <= 1'b1;
    step(4);
    chk({BATTERY_FAIL_FLAG, BATT_WARN_IRQ}, 2'h3, "battery flags");
    chk({REGULATOR_TEMP_WARN_MCR, REGULATOR_TEMP_WARN_INT}, 2'h3, "temp warn flags");
    chk({SECOND_REG_LOW, SWITCH_OVERTEMP, SWITCH_OR_SECOND_LOW}, 3'h7, "switch flags");
    chk(HIGH_SIDE_SWITCH, 1'b0, "switch off while overheated");
    @(posedge CLK);
    {BATT_BELOW_3V, BATT_BELOW_6V, REG_TEMP_WARN, SECOND_REG_BELOW_4V, SWITCH_OVERTEMP_IN} <= 5'h0;
    BATT_WARN_MASK <= 1'b1;
    REG_TEMP_SHUTDOWN <= 1'b1;
    step(4);
    chk({BATT_WARN_FLAG, BATT_WARN_IRQ}, 2'h2, "masked warning stands");
    chk(MAIN_REG_ON, 1'b0, "regulator hot shutdown");
    @(posedge CLK);
    FLAG_CLEAR <= 1'b1;
    REG_TEMP_SHUTDOWN <= 1'b0;
    BATT_WARN_MASK <= 1'b0;
    @(posedge CLK);
    FLAG_CLEAR <= 1'b0;
    step(4);
    chk({BATTERY_FAIL_FLAG, BATT_WARN_FLAG, SECOND_REG_LOW}, 3'h0, "flags cleared");
    $display("test flags done");
    host.send_mode(REQ_STANDBY);
    step(5);
    chk(MODE, SMC_STANDBY, "standby entered");
    chk({MAIN_REG_ON, SECOND_REG_DRIVE, HIGH_SIDE_SWITCH}, 3'h5, "standby supplies");
    chk({CAN_TX_ENABLE, WATCHDOG_RUN}, 2'h1, "standby can and watchdog");
    @(posedge CLK);
    CAN_RX_ACTIVE <= 1'b1;
    step(4);
    chk(CAN_WAKE_FLAG, 1'b1, "can wake in standby");
    @(posedge CLK);
    CAN_RX_ACTIVE <= 1'b0;
    SWITCH_ON_BIT <= 1'b0;
    host.send_mode(REQ_NORMAL);
    step(5);
    chk(MODE, SMC_NORMAL, "back to normal");
    $display("test standby done");
    host.send_mode(REQ_STOP);
    step(5);
    chk(MODE, SMC_STOP, "stop entered");
    chk({MAIN_REG_LOW_CURRENT, SECOND_REG_DRIVE, SLOW_OSC_SEL}, 3'h5, "stop supplies");
    chk(WATCHDOG_RUN, 1'b0, "watchdog stopped by bit");
    @(posedge CLK);
    STOP_WATCHDOG_ENABLE <= 1'b1;
    step(2);
    chk(WATCHDOG_RUN, 1'b1, "watchdog runs by bit in stop");
    @(posedge CLK);
    STOP_WATCHDOG_ENABLE <= 1'b0;
    @(posedge CLK);
    BATT_BELOW_6V <= 1'b1;
    WATCHDOG_FAULT <= 1'b1;
    host.send_mode(REQ_NORMAL);
    step(5);
    chk(BATT_WARN_FLAG, 1'b0, "no warning in stop");
    chk(MODE, SMC_STOP, "stop ignores request and fault");
    @(posedge CLK);
    BATT_BELOW_6V <= 1'b0;
    WATCHDOG_FAULT <= 1'b0;
    step(4);
    saw_reset = 1'b0;
    host.cs_wake();
    wait_mode(SMC_NORMAL_REQ, 20, "chip select wake");
    chk(saw_reset, 1'b0, "stop wake skips reset");
    host.configure();
    step(1);
    chk(MODE, SMC_NORMAL, "normal after stop");
    $display("test stop done");
    @(posedge CLK);
    WATCHDOG_FAULT <= 1'b1;
    step(4);
    chk({MODE, RESET_N}, 4'h0, "watchdog fault resets");
    @(posedge CLK);
    WATCHDOG_FAULT <= 1'b0;
    wait_mode(SMC_NORMAL_REQ, 25000, "fault reset ends");
    host.configure();
    step(1);
    chk(MODE, SMC_NORMAL, "normal after fault");
    $display("test watchdog fault done");
    @(posedge CLK);
    WAKE_ENABLE <= 4'h1;
    host.send_mode(REQ_SLEEP);
    step(5);
    chk(MODE, SMC_SLEEP, "sleep entered");
    chk({MAIN_REG_ON, SECOND_REG_DRIVE, RESET_N}, 3'h0, "sleep supplies off");
    chk(SLOW_OSC_SEL, 1'b1, "slow oscillator asleep");
    @(posedge CLK);
    WAKE_INPUTS <= 4'h1;
    wait_mode(SMC_RESET, 45000, "level wake");
    wait_mode(SMC_NORMAL_REQ, 25000, "sleep wake via reset");
    wait_mode(SMC_SLEEP, 25000, "unconfigured back to sleep");
    $display("test sleep done");
    conclude();
  end
endmodule // test_sbc_mode_controller
